// >>> rtl/dtssp_pkg.sv
// constants, codes and register layout of the transmit serial system port
// assumes a 50 MHz system clock and a classic wishbone register bus
package dtssp_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DATA   = 8'h08;

	// control register fields (port_control_three)
	localparam int F_MODE_LO   = 0;
	localparam int F_MODE_HI   = 1;
	localparam int F_FUNC_DEN  = 2;
	localparam int F_REF_LO    = 3;
	localparam int F_REF_HI    = 5;
	localparam int F_DCK_LO    = 6;
	localparam int F_DCK_HI    = 8;
	localparam int F_TCLK_GAP  = 9;
	localparam int F_INV_ALIGN = 10;
	localparam int F_INV_DATA  = 11;
	localparam int F_INV_CLKO  = 12;
	localparam int F_INV_MARK  = 13;
	localparam int F_INV_REF   = 14;
	localparam int F_INV_DCK   = 15;
	localparam int F_LOOP      = 16;
	localparam int F_ADAPT     = 17;
	localparam int CTRL_BITS   = 18;
	localparam logic [CTRL_BITS-1:0] CTRL_RESET = 18'h00000;

	// status and data register fields
	localparam int S_ALIGNED  = 0;
	localparam int S_OVERFLOW = 1;
	localparam int S_LVL_LO   = 4;
	localparam int S_LVL_HI   = 7;
	localparam int S_NONEMPTY = 8;
	localparam int D_VALID    = 8;

	// operating modes
	localparam logic [1:0] MODE_CLEAR = 2'h0;
	localparam logic [1:0] MODE_DS3   = 2'h1;
	localparam logic [1:0] MODE_E3    = 2'h2;

	// clock source codes, shared by the reference and data clock selects
	localparam int CK_TX_IN   = 0;
	localparam int CK_TX_LINE = 1;
	localparam int CK_TX_OUT  = 2;
	localparam int CK_RX_OUT  = 3;
	localparam int CK_RX_LINE = 4;
	localparam int CK_GAPPED  = 5;
	localparam int CK_COUNT   = 6;

	// frame geometry: overhead bits at the head of every block
	localparam int POS_W = 13;
	localparam logic [POS_W-1:0] DS3_FRAME = 13'h1298; // 4760 bits
	localparam logic [POS_W-1:0] DS3_BLOCK = 13'h0055; // 85 bits
	localparam logic [POS_W-1:0] DS3_OH    = 13'h0001;
	localparam logic [POS_W-1:0] E3_FRAME  = 13'h0600; // 1536 bits
	localparam logic [POS_W-1:0] E3_BLOCK  = 13'h0600;
	localparam logic [POS_W-1:0] E3_OH     = 13'h000c; // 12 bits
	localparam logic [POS_W-1:0] LEAD      = 13'h0003; // marker lead in clocks

	// payload word path
	localparam int WORD_W     = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int LVL_W      = 4;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// rate adapter clock made from the system clock (half period in cycles)
	localparam int ADAPT_HALF = 1;
endpackage

// >>> rtl/dtssp_top.sv
// transmit serial system port: frame timing, marker/enable pin, clock out, payload capture
// assumes all pin inputs are asynchronous to CLOCK and slower than CLOCK/4
//
// Behaviour
// - rising align edge sets frame start position
// - missing or static align keeps current timing
// - align sampled on reference edge, data on data clock edge
// - reference clock chosen among five sources
// - framed modes take payload from serial input
// - clear channel takes every serial bit
// - data may also reference the gapped clock
// - continuous select drives framer clock out
// - gapped select gates clock by payload enable
// - each port signal has its own inversion
// - frame marker pulses three clocks early
// - enable rises and falls three clocks early
// - marker/enable updated on reference edge
// - one pin, function selectable, framed only
// - clock input ignored when loop or adapter
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps

// word fifo with valid/ready on both sides
module dtssp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic [WIDTH-1:0]           in_data,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	output logic [WIDTH-1:0]                out_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic             push;
	logic             pop;

	assign in_ready  = (level != DEPTH[$clog2(DEPTH+1)-1:0]);
	assign out_valid = (level != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// storage array
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push & ~pop) begin
				level <= level + 1'b1;
			end else if (pop & ~push) begin
				level <= level - 1'b1;
			end
		end
	end
endmodule

module dtssp_top (
	input  wire logic                 CLOCK,
	input  wire logic                 RESET_N,
	input  wire logic                 WB_CYC_I,
	input  wire logic                 WB_STB_I,
	input  wire logic                 WB_WE_I,
	input  wire logic [7:0]           WB_ADR_I,
	input  wire logic [3:0]           WB_SEL_I,
	input  wire logic [31:0]          WB_DAT_I,
	output logic      [31:0]          WB_DAT_O,
	output logic                      WB_ACK_O,
	input  wire logic                 TX_FRAME_ALIGN_IN,
	input  wire logic                 TX_SERIAL_DATA_IN,
	input  wire logic                 TX_CLOCK_IN,
	input  wire logic                 TX_LINE_CLOCK,
	input  wire logic                 RX_CLOCK_OUT,
	input  wire logic                 RX_LINE_CLOCK,
	output logic                      TX_CLOCK_OUT,
	output logic                      TX_FRAME_MARKER_OUT
);
	import dtssp_pkg::*;

	// pin index in the synchroniser vector
	localparam int P_ALIGN = 0;
	localparam int P_DATA  = 1;
	localparam int P_TCLK  = 2;
	localparam int P_TLINE = 3;
	localparam int P_RCLK  = 4;
	localparam int P_RLINE = 5;
	localparam int P_N     = 6;

	logic [P_N-1:0]       sync_a;
	logic [P_N-1:0]       sync_b;
	logic [CTRL_BITS-1:0] port_control_three;
	logic [1:0]           mode;
	logic                 framed;
	logic                 div_clk;
	logic [3:0]           div_cnt;
	logic                 framer_src;
	logic                 clk_out_lvl;
	logic                 gap_out_lvl;
	logic                 den_lvl;
	logic [CK_COUNT-1:0]  ck_vec;
	logic                 ref_lvl;
	logic                 ref_prev;
	logic                 ref_edge;
	logic                 dck_lvl;
	logic                 dck_prev;
	logic                 dck_edge;
	logic                 align_lvl;
	logic                 align_prev;
	logic                 align_rise;
	logic [POS_W-1:0]     frm_pos;
	logic [POS_W-1:0]     blk_pos;
	logic [POS_W-1:0]     next_frm_pos;
	logic [POS_W-1:0]     next_blk_pos;
	logic [2:0]           pay_pipe;
	logic                 take_bit;
	logic                 data_bit;
	logic [WORD_W-2:0]    shifter;
	logic [2:0]           bit_cnt;
	logic [WORD_W-1:0]    word;
	logic                 word_valid;
	logic                 word_ready;
	logic [WORD_W-1:0]    fifo_data;
	logic                 fifo_valid;
	logic                 fifo_pop;
	logic [LVL_W-1:0]     fifo_level;
	logic                 aligned_flag;
	logic                 overflow_flag;
	logic                 bus_req;
	logic                 wr_ctrl;
	logic                 wr_status;
	logic                 rd_data;
	logic                 overflow_evt;

	// frame length of the current mode
	function automatic logic [POS_W-1:0] frame_len(input logic [1:0] m);
		frame_len = (m == MODE_E3) ? E3_FRAME : DS3_FRAME;
	endfunction

	// block length of the current mode
	function automatic logic [POS_W-1:0] block_len(input logic [1:0] m);
		block_len = (m == MODE_E3) ? E3_BLOCK : DS3_BLOCK;
	endfunction

	// true when a block position carries payload
	function automatic logic is_payload(input logic [1:0] m, input logic [POS_W-1:0] b);
		is_payload = (b >= ((m == MODE_E3) ? E3_OH : DS3_OH));
	endfunction

	// clock level of a source code, the gapped clock only where allowed
	function automatic logic pick_clock(input logic [2:0] sel,
		input logic [CK_COUNT-1:0] v, input logic allow_gap);
		if (sel < 3'(CK_GAPPED)) begin
			pick_clock = v[sel];
		end else if (sel == 3'(CK_GAPPED) && allow_gap) begin
			pick_clock = v[CK_GAPPED];
		end else begin
			pick_clock = 1'b0;
		end
	endfunction

	assign mode   = port_control_three[F_MODE_HI:F_MODE_LO];
	assign framed = (mode == MODE_DS3) || (mode == MODE_E3);

	// two-stage synchronisers for every pin input
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {RX_LINE_CLOCK, RX_CLOCK_OUT, TX_LINE_CLOCK, TX_CLOCK_IN,
				TX_SERIAL_DATA_IN, TX_FRAME_ALIGN_IN};
			sync_b <= sync_a;
		end
	end

	// rate adapter clock divided down from the system clock
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			div_cnt <= '0;
			div_clk <= 1'b0;
		end else if (div_cnt == 4'(ADAPT_HALF - 1)) begin
			div_cnt <= '0;
			div_clk <= ~div_clk;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	// framer clock source; the clock input is not looked at in loop or adapter timing
	always_comb begin
		if (port_control_three[F_LOOP]) begin
			framer_src = sync_b[P_RLINE];
		end else if (port_control_three[F_ADAPT]) begin
			framer_src = div_clk;
		end else begin
			framer_src = sync_b[P_TCLK];
		end
	end

	// clock output, continuous or gated by the payload enable
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			clk_out_lvl  <= 1'b0;
			gap_out_lvl  <= 1'b0;
			TX_CLOCK_OUT <= 1'b0;
		end else begin
			clk_out_lvl <= framer_src;
			gap_out_lvl <= framer_src & den_lvl;
			if (port_control_three[F_TCLK_GAP]) begin
				TX_CLOCK_OUT <= (framer_src & den_lvl) ^ port_control_three[F_INV_CLKO];
			end else begin
				TX_CLOCK_OUT <= framer_src ^ port_control_three[F_INV_CLKO];
			end
		end
	end

	// selectable reference and data clocks with their own inversion
	assign ck_vec    = {gap_out_lvl, sync_b[P_RLINE], sync_b[P_RCLK], clk_out_lvl,
		sync_b[P_TLINE], sync_b[P_TCLK]};
	assign ref_lvl   = pick_clock(port_control_three[F_REF_HI:F_REF_LO], ck_vec, 1'b0)
		^ port_control_three[F_INV_REF];
	assign dck_lvl   = pick_clock(port_control_three[F_DCK_HI:F_DCK_LO], ck_vec, 1'b1)
		^ port_control_three[F_INV_DCK];
	assign ref_edge  = ref_lvl & ~ref_prev;
	assign dck_edge  = dck_lvl & ~dck_prev;
	assign align_lvl = sync_b[P_ALIGN] ^ port_control_three[F_INV_ALIGN];
	assign align_rise = ref_edge & align_lvl & ~align_prev;

	// edge finders for the selected clocks and the align input
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			ref_prev   <= 1'b0;
			dck_prev   <= 1'b0;
			align_prev <= 1'b0;
		end else begin
			ref_prev <= ref_lvl;
			dck_prev <= dck_lvl;
			if (ref_edge) begin
				align_prev <= align_lvl;
			end
		end
	end

	// next look-ahead position, three bits ahead of the sampled one
	always_comb begin
		next_frm_pos = frm_pos + 1'b1;
		next_blk_pos = blk_pos + 1'b1;
		if (next_frm_pos >= frame_len(mode)) begin
			next_frm_pos = '0;
			next_blk_pos = '0;
		end else if (next_blk_pos >= block_len(mode)) begin
			next_blk_pos = '0;
		end
	end

	// frame timing counters; held at zero in clear channel, otherwise free-running unless an align edge arrives
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			frm_pos  <= '0;
			blk_pos  <= '0;
			pay_pipe <= '0;
		end else if (!framed) begin
			frm_pos  <= '0;
			blk_pos  <= '0;
			pay_pipe <= '0;
		end else if (align_rise) begin
			frm_pos  <= LEAD;
			blk_pos  <= LEAD;
			pay_pipe <= {is_payload(mode, POS_W'(0)), is_payload(mode, POS_W'(1)),
				is_payload(mode, POS_W'(2))};
		end else if (ref_edge) begin
			frm_pos  <= next_frm_pos;
			blk_pos  <= next_blk_pos;
			pay_pipe <= {pay_pipe[1:0], is_payload(mode, blk_pos)};
		end
	end

	// shared marker/enable pin, driven three bits ahead on the reference edge
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			den_lvl             <= 1'b0;
			TX_FRAME_MARKER_OUT <= 1'b0;
		end else if (ref_edge) begin
			den_lvl <= framed & is_payload(mode, blk_pos);
			if (!framed) begin
				TX_FRAME_MARKER_OUT <= port_control_three[F_INV_MARK];
			end else if (port_control_three[F_FUNC_DEN]) begin
				TX_FRAME_MARKER_OUT <= is_payload(mode, blk_pos)
					^ port_control_three[F_INV_MARK];
			end else begin
				TX_FRAME_MARKER_OUT <= (frm_pos == '0)
					^ port_control_three[F_INV_MARK];
			end
		end
	end

	// which data clock edges carry a bit for us
	always_comb begin
		data_bit = sync_b[P_DATA] ^ port_control_three[F_INV_DATA];
		if (mode == MODE_CLEAR) begin
			take_bit = dck_edge;
		end else if (port_control_three[F_DCK_HI:F_DCK_LO] == 3'(CK_GAPPED)) begin
			take_bit = framed & dck_edge;
		end else begin
			take_bit = framed & dck_edge & pay_pipe[2];
		end
	end

	assign overflow_evt = take_bit & (bit_cnt == LAST_BIT) & word_valid & ~word_ready;

	// bits gathered into words, msb first; a word completed while one is still held is dropped
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			shifter    <= '0;
			bit_cnt    <= '0;
			word       <= '0;
			word_valid <= 1'b0;
		end else begin
			if (word_valid & word_ready) begin
				word_valid <= 1'b0;
			end
			if (take_bit) begin
				if (bit_cnt == LAST_BIT) begin
					bit_cnt <= '0;
					if (!(word_valid & ~word_ready)) begin
						word       <= {shifter, data_bit};
						word_valid <= 1'b1;
					end
				end else begin
					shifter <= {shifter[WORD_W-3:0], data_bit};
					bit_cnt <= bit_cnt + 1'b1;
				end
			end
		end
	end

	dtssp_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (CLOCK),
		.rst_n     (RESET_N),
		.in_data   (word),
		.in_valid  (word_valid),
		.in_ready  (word_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.level     (fifo_level)
	);

	// bus decode; a request is answered one cycle after it is seen
	assign bus_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	assign wr_ctrl   = bus_req & WB_WE_I & (WB_ADR_I == ADDR_CTRL);
	assign wr_status = bus_req & WB_WE_I & (WB_ADR_I == ADDR_STATUS);
	assign rd_data   = bus_req & ~WB_WE_I & (WB_ADR_I == ADDR_DATA);
	assign fifo_pop  = rd_data & fifo_valid;

	// control register, byte lanes honoured
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			port_control_three <= CTRL_RESET;
		end else if (wr_ctrl) begin
			for (int i = 0; i < CTRL_BITS; i++) begin
				if (WB_SEL_I[i / 8]) begin
					port_control_three[i] <= WB_DAT_I[i];
				end
			end
		end
	end

	// sticky status flags, write one to clear, a new event wins
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			aligned_flag  <= 1'b0;
			overflow_flag <= 1'b0;
		end else begin
			if (align_rise & framed) begin
				aligned_flag <= 1'b1;
			end else if (wr_status & WB_SEL_I[0] & WB_DAT_I[S_ALIGNED]) begin
				aligned_flag <= 1'b0;
			end
			if (overflow_evt) begin
				overflow_flag <= 1'b1;
			end else if (wr_status & WB_SEL_I[0] & WB_DAT_I[S_OVERFLOW]) begin
				overflow_flag <= 1'b0;
			end
		end
	end

	// acknowledge and read data
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= '0;
		end else begin
			WB_ACK_O <= bus_req;
			WB_DAT_O <= '0;
			if (bus_req & ~WB_WE_I) begin
				case (WB_ADR_I)
					ADDR_CTRL: begin
						WB_DAT_O[CTRL_BITS-1:0] <= port_control_three;
					end
					ADDR_STATUS: begin
						WB_DAT_O[S_ALIGNED]           <= aligned_flag;
						WB_DAT_O[S_OVERFLOW]          <= overflow_flag;
						WB_DAT_O[S_LVL_HI:S_LVL_LO]   <= fifo_level;
						WB_DAT_O[S_NONEMPTY]          <= fifo_valid;
					end
					ADDR_DATA: begin
						WB_DAT_O[WORD_W-1:0] <= fifo_valid ? fifo_data : '0;
						WB_DAT_O[D_VALID]    <= fifo_valid;
					end
					default: begin
						WB_DAT_O <= '0;
					end
				endcase
			end
		end
	end
endmodule

// >>> verification/dtssp_chk_assertions.sv
// checker for the transmit serial port top: bus handshake, marker pin, clock out
// assumes classic wishbone cycles and a 160 ns transmit clock pin
`timescale 1ns/100ps
module dtssp_chk
	import dtssp_pkg::*;
(
	input wire logic        CLOCK,
	input wire logic        RESET_N,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic [7:0]  WB_ADR_I,
	input wire logic [3:0]  WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_ACK_O,
	input wire logic        TX_CLOCK_IN,
	input wire logic        TX_CLOCK_OUT,
	input wire logic        TX_FRAME_MARKER_OUT
);
	logic [CTRL_BITS-1:0] ctrl;
	logic [23:0]          lane;
	logic [4:0]           age;
	logic                 wr;
	logic                 settled;
	logic                 framed;

	// control write strobe, lane mask and derived mode flags
	assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_ADR_I == ADDR_CTRL;
	assign lane = {{8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
	assign settled = age == 5'h1f;
	assign framed = ctrl[F_MODE_HI:F_MODE_LO] != MODE_CLEAR;

	// shadow of the control register
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl <= CTRL_RESET;
		end else if (wr) begin
			ctrl <= (ctrl & ~lane[17:0]) | (WB_DAT_I[17:0] & lane[17:0]);
		end
	end

	// cycles since the last control write, saturating
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			age <= 5'h0;
		end else if (wr) begin
			age <= 5'h0;
		end else if (!settled) begin
			age <= age + 5'h1;
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);

	property p_ack_next;
		WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_pulse;
		WB_ACK_O |=> !WB_ACK_O;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_dat_zero;
		!WB_ACK_O |-> WB_DAT_O == 32'h0;
	endproperty
	a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
	property p_ctrl_rd;
		WB_ACK_O && !WB_WE_I && WB_ADR_I == ADDR_CTRL |-> WB_DAT_O == {14'h0, ctrl};
	endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
	property p_clear_mark;
		settled && !framed |-> TX_FRAME_MARKER_OUT == ctrl[F_INV_MARK];
	endproperty
	a_clear_mark: assert property (p_clear_mark) else $error("marker active in clear");
	property p_mark_width;
		$rose(TX_FRAME_MARKER_OUT) && settled && framed && !ctrl[F_FUNC_DEN]
			&& !ctrl[F_INV_MARK] && !ctrl[F_INV_REF] && ctrl[F_REF_HI:F_REF_LO] == 3'h0
			|-> TX_FRAME_MARKER_OUT[*8] ##1 !TX_FRAME_MARKER_OUT;
	endproperty
	a_mark_width: assert property (p_mark_width) else $error("marker width");
	property p_adapt;
		settled && ctrl[F_ADAPT] && !ctrl[F_LOOP] && !ctrl[F_TCLK_GAP]
			|=> TX_CLOCK_OUT != $past(TX_CLOCK_OUT);
	endproperty
	a_adapt: assert property (p_adapt) else $error("adapter clock stalled");
	property p_clk_follow;
		settled && !ctrl[F_LOOP] && !ctrl[F_ADAPT] && !ctrl[F_TCLK_GAP] && !ctrl[F_INV_CLKO]
			&& $rose(TX_CLOCK_IN) |-> ##[1:5] $rose(TX_CLOCK_OUT);
	endproperty
	a_clk_follow: assert property (p_clk_follow) else $error("clock out missing");
	c_marker: cover property ($rose(TX_FRAME_MARKER_OUT));
	c_word: cover property (WB_ACK_O && WB_ADR_I == ADDR_DATA && WB_DAT_O[D_VALID]);
	c_adapt: cover property (settled && ctrl[F_ADAPT]);
endmodule

bind dtssp_top dtssp_chk dtssp_chk_i (
	.CLOCK(CLOCK), .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .TX_CLOCK_IN(TX_CLOCK_IN),
	.TX_CLOCK_OUT(TX_CLOCK_OUT), .TX_FRAME_MARKER_OUT(TX_FRAME_MARKER_OUT)
);

// >>> verification/dtssp_src.sv
// system-side source model: makes the transmit clock pin and serial payload
// assumes the bench queues bytes with send and sets run for a free clock
`timescale 1ns/100ps
module dtssp_src (
	input  wire logic run,
	output logic      link_clk,
	output logic      data
);
	bit   bq[$];
	logic busy;

	// queue a byte, msb first
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			bq.push_back(b[i]);
		end
	endtask

	// half-period ticks off the system clock phase; data moves after a fall
	initial begin
		link_clk = 1'b0;
		data = 1'b0;
		busy = 1'b0;
		#7;
		forever begin
			#80;
			if (link_clk) begin
				link_clk = 1'b0;
				busy = bq.size() != 0;
				data = busy ? bq.pop_front() : ~data;
			end else if (busy || run) begin
				link_clk = 1'b1;
			end else if (bq.size() != 0) begin
				data = bq.pop_front();
				busy = 1'b1;
			end
		end
	end
endmodule

// >>> verification/dtssp_top_tb.sv
// self-checking bench for the transmit serial port top
// assumes the source model drives the transmit clock pin and serial data
`timescale 1ns/100ps
module dtssp_top_tb;
	import dtssp_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dwr = 32'h0;
	logic [31:0] dat_o;
	logic        ack;
	logic        align = 1'b0;
	logic        run = 1'b0;
	logic        link_clk;
	logic        sdata;
	logic        tx_clock_out;
	logic        mark;
	logic [31:0] r;
	int          cyc_n = 0;
	int          fail_count = 0;
	int          tests_run = 0;
	int          t0;
	int          t1;
	int          n;

	// clock and cycle count
	always #10 clk = ~clk;
	always @(posedge clk) cyc_n <= cyc_n + 1;

	dtssp_top dtssp_top_i (
		.CLOCK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dwr), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
		.TX_FRAME_ALIGN_IN(align), .TX_SERIAL_DATA_IN(sdata), .TX_CLOCK_IN(link_clk),
		.TX_LINE_CLOCK(1'b0), .RX_CLOCK_OUT(1'b0), .RX_LINE_CLOCK(1'b0),
		.TX_CLOCK_OUT(tx_clock_out), .TX_FRAME_MARKER_OUT(mark)
	);
	dtssp_src dtssp_src_i (.run(run), .link_clk(link_clk), .data(sdata));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chkr(input string nm, input int lo, input int hi, input int g);
		tests_run++;
		if (g < lo || g > hi) begin
			fail_count++;
			$display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask

	// one classic wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q);
		int k;
		k = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dwr <= d;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = dat_o;
		chk("ack", 32'h1, {31'h0, ack});
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// wait for the marker pin to enter a level after leaving it
	task automatic wait_mark(input logic lvl, output int t);
		int k;
		k = 0;
		while (mark === lvl && k < 14000) begin
			@(posedge clk);
			k++;
		end
		while (mark !== lvl && k < 14000) begin
			@(posedge clk);
			k++;
		end
		t = cyc_n;
	endtask

	task automatic count_clk(input int len, output int c);
		logic p;
		c = 0;
		p = tx_clock_out;
		repeat (len) begin
			@(posedge clk);
			if (tx_clock_out === 1'b1 && p === 1'b0) c++;
			p = tx_clock_out;
		end
	endtask

	task automatic t_regs;
		wb(0, ADDR_CTRL, 4'hf, 32'h0, r);
		chk("ctrl reset", {14'h0, CTRL_RESET}, r);
		wb(1, ADDR_CTRL, 4'h4, 32'hffffffff, r);
		wb(0, ADDR_CTRL, 4'hf, 32'h0, r);
		chk("ctrl lane", 32'h00030000, r);
		wb(1, ADDR_CTRL, 4'hf, 32'h0, r);
		wb(0, 8'h0c, 4'hf, 32'h0, r);
		chk("unmapped", 32'h0, r);
	endtask

	task automatic t_fifo;
		// ten bytes: eight fill the fifo, one waits in the gatherer, the last is dropped
		for (int i = 0; i < 10; i++) dtssp_src_i.send(8'ha0 + 8'(i));
		n = 0;
		while ((dtssp_src_i.busy || dtssp_src_i.bq.size() != 0) && n < 2000) begin
			@(posedge clk);
			n++;
		end
		repeat (20) @(posedge clk);
		wb(0, ADDR_STATUS, 4'hf, 32'h0, r);
		chk("status full", 32'h00000182, r);
		for (int i = 0; i < 8; i++) begin
			wb(0, ADDR_DATA, 4'hf, 32'h0, r);
			chk("word", 32'h00000100 | (32'ha0 + i), r);
		end
		wb(0, ADDR_DATA, 4'hf, 32'h0, r);
		chk("held word", 32'h000001a8, r);
		wb(0, ADDR_DATA, 4'hf, 32'h0, r);
		chk("empty", 32'h0, {31'h0, r[D_VALID]});
		wb(1, ADDR_STATUS, 4'h1, 32'h2, r);
		wb(0, ADDR_STATUS, 4'hf, 32'h0, r);
		chk("status clear", 32'h0, r);
	endtask

	task automatic t_frame;
		run <= 1'b1;
		wb(1, ADDR_CTRL, 4'hf, {30'h0, MODE_E3}, r);
		repeat (40) @(posedge clk);
		@(negedge link_clk);
		@(posedge clk);
		align <= 1'b1;
		@(posedge link_clk);
		t0 = cyc_n;
		repeat (20) @(posedge clk);
		wait_mark(1'b1, t1);
		// align edge loads look-ahead position 3; marker latches when it wraps to 0
		chkr("align to marker", 1534 * 8, 1534 * 8 + 10, t1 - t0);
		wait_mark(1'b1, t0);
		chk("frame period", 32'(1536 * 8), t0 - t1);
		align <= 1'b0;
		repeat (12) @(posedge clk);
		wb(0, ADDR_STATUS, 4'hf, 32'h0, r);
		chk("align seen", 32'h1, {31'h0, r[S_ALIGNED]});
	endtask

	task automatic t_enable;
		wb(1, ADDR_CTRL, 4'hf, 32'h00000204 | MODE_E3, r);
		wait_mark(1'b0, t0);
		wait_mark(1'b1, t1);
		chk("enable low", 32'(12 * 8), t1 - t0);
		count_clk(1536 * 8, n);
		chkr("gapped pulses", 1523, 1525, n);
	endtask

	task automatic t_clocks;
		logic [31:0] cv [3] = '{32'h0, 32'h00010000, 32'h00022000};
		int          ex [3] = '{10, 0, 40};
		for (int i = 0; i < 3; i++) begin
			wb(1, ADDR_CTRL, 4'hf, cv[i], r);
			repeat (30) @(posedge clk);
			count_clk(80, n);
			chkr("clock out pulses", ex[i] - 1, ex[i] + 1, n);
			chk("marker level", {31'h0, cv[i][F_INV_MARK]}, {31'h0, mark});
		end
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_fifo();
		t_frame();
		t_enable();
		t_clocks();
		conclude();
	end

	// watchdog
	initial begin
		repeat (90000) @(posedge clk);
		fail_count++;
		conclude();
	end
endmodule
